/* File: rtl/byte_alu_pkg.sv */
// Package of opcodes, destination selects, sequencer states, reset values and widths for the byte ALU datapath.
package byte_alu_pkg;

    // -----------------------------------------------------------------
    // Widths and reset values
    // -----------------------------------------------------------------
    localparam int        DATA_W      = 8;
    localparam int        ADDR_W      = 7;
    localparam int        BIT_IDX_W   = 3;
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // -----------------------------------------------------------------
    // Destination select values
    // -----------------------------------------------------------------
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // -----------------------------------------------------------------
    // Operation codes presented by the decoder
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE                    = 4'h0,
        OP_ADD_IMMEDIATE_TO_ACC    = 4'h1,
        OP_ADD_ACC_TO_FILE         = 4'h2,
        OP_AND_IMMEDIATE_WITH_ACC  = 4'h3,
        OP_AND_ACC_WITH_FILE       = 4'h4,
        OP_FILE_BIT_CLEAR          = 4'h5,
        OP_FILE_BIT_SET            = 4'h6,
        OP_TEST_BIT_SKIP_IF_ZERO   = 4'h7,
        OP_SUBTRACT_ACC_FROM_FILE  = 4'h8,
        OP_NIBBLE_EXCHANGE         = 4'h9,
        OP_XOR_IMMEDIATE_WITH_ACC  = 4'hA,
        OP_XOR_ACC_WITH_FILE       = 4'hB
    } alu_op_t;

    // -----------------------------------------------------------------
    // Sequencer states for the skip slot
    // -----------------------------------------------------------------
    typedef enum logic [0:0] {
        SEQ_RUN  = 1'b0,
        SEQ_SKIP = 1'b1
    } seq_state_t;

endpackage

/* File: rtl/byte_alu.sv */
// Byte ALU datapath executing a subset of byte and bit instructions with accumulator and flags.
`timescale 1ns/1ps

module byte_alu #(
    parameter int DATA_W = byte_alu_pkg::DATA_W,
    parameter int ADDR_W = byte_alu_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    // Instruction from the decoder
    input  wire logic                         instr_valid,
    input  wire byte_alu_pkg::alu_op_t        instr_op,
    input  wire logic [7:0]                   instr_immediate,
    input  wire logic [ADDR_W-1:0]            instr_file_addr,
    input  wire logic [2:0]                   instr_bit_idx,
    input  wire logic                         instr_dest,
    // Operand read from the data memory file
    input  wire logic [7:0]                   file_rd_data,
    // File address request and write-back
    output logic [ADDR_W-1:0]                 file_rd_addr,
    output logic                              file_wr_en,
    output logic [ADDR_W-1:0]                 file_wr_addr,
    output logic [7:0]                        file_wr_data,
    // Accumulator and status flags
    output logic [7:0]                        acc,
    output logic                              carry_flag,
    output logic                              half_carry_flag,
    output logic                              zero_flag,
    // Sequencer view of the skip slot
    output logic                              skip_active,
    output logic                              instr_accepted
);

    // -----------------------------------------------------------------
    // Elaboration checks
    // -----------------------------------------------------------------
    // The datapath is byte wide and the file space must fit a 7-bit operand field.
    if (DATA_W != 8) begin : g_bad_width
        $error("byte_alu supports only an 8-bit data path");
    end
    // A narrower file space is allowed; addresses above it then simply do not exist.
    if (ADDR_W < 1 || ADDR_W > byte_alu_pkg::ADDR_W) begin : g_bad_addr
        $error("byte_alu address width out of range");
    end

    // -----------------------------------------------------------------
    // Arithmetic helpers
    // -----------------------------------------------------------------
    // Nine-bit sum so that the carry out of bit 7 is kept.
    function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b);
        add9 = {1'b0, a} + {1'b0, b};
    endfunction

    // Five-bit low-nibble sum so that the carry out of bit 3 is kept.
    function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b);
        add5 = {1'b0, a} + {1'b0, b};
    endfunction

    // One-hot mask of a bit index.
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    // Destination decode shared by every file-operand instruction with a select bit.
    function automatic logic dest_is_file(input logic dest);
        dest_is_file = (dest == byte_alu_pkg::DEST_FILE);
    endfunction

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    byte_alu_pkg::seq_state_t seq_state;
    byte_alu_pkg::seq_state_t next_seq_state;
    logic                     exec;
    logic [7:0]               next_result;
    logic                     next_to_file;
    logic                     next_to_acc;
    logic                     upd_c;
    logic                     upd_dc;
    logic                     upd_z;
    logic                     next_c;
    logic                     next_dc;
    logic                     skip_req;
    logic [8:0]               sum9;
    logic [4:0]               sum5;
    logic [8:0]               diff9;
    logic [4:0]               diff5;
    logic [7:0]               b_operand;

    // -----------------------------------------------------------------
    // Skip slot sequencing
    // -----------------------------------------------------------------
    // The instruction that lands in the skip slot is taken but not executed,
    // so it behaves as a no-operation and the test costs two cycles.
    assign exec           = instr_valid && (seq_state == byte_alu_pkg::SEQ_RUN);
    assign instr_accepted = instr_valid;
    assign skip_active    = (seq_state == byte_alu_pkg::SEQ_SKIP);
    assign file_rd_addr   = instr_file_addr;

    // Skip is requested when the tested file bit reads zero.
    assign skip_req = exec && (instr_op == byte_alu_pkg::OP_TEST_BIT_SKIP_IF_ZERO)
                      && !file_rd_data[instr_bit_idx];

    // An idle cycle leaves a pending skip armed, so the discard always hits a real instruction.
    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            byte_alu_pkg::SEQ_RUN: begin
                if (skip_req) begin
                    next_seq_state = byte_alu_pkg::SEQ_SKIP;
                end
            end
            byte_alu_pkg::SEQ_SKIP: begin
                // Leave only once the discarded instruction has been consumed.
                if (instr_valid) begin
                    next_seq_state = byte_alu_pkg::SEQ_RUN;
                end
            end
            default: begin
                next_seq_state = byte_alu_pkg::SEQ_RUN;
            end
        endcase
    end

    // Reset drops any pending skip, so the first instruction after it always executes.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            seq_state <= byte_alu_pkg::SEQ_RUN;
        end else begin
            seq_state <= next_seq_state;
        end
    end

    // -----------------------------------------------------------------
    // Operand arithmetic
    // -----------------------------------------------------------------
    // Literal forms use the immediate, file forms the file operand.
    assign b_operand = (instr_op == byte_alu_pkg::OP_ADD_IMMEDIATE_TO_ACC) ? instr_immediate : file_rd_data;
    assign sum9      = add9(acc, b_operand);
    assign sum5      = add5(acc[3:0], b_operand[3:0]);
    // File minus accumulator as file plus two's complement of the accumulator;
    // the carry out then reads one exactly when there was no borrow.
    assign diff9     = add9(file_rd_data, 8'(~acc)) + 9'h001;
    assign diff5     = add5(file_rd_data[3:0], 4'(~acc[3:0])) + 5'h01;

    // -----------------------------------------------------------------
    // Result and flag selection
    // -----------------------------------------------------------------
    // Decode the operation into a result byte, its destination and the flags that it owns.
    // Every output has a default first, so unused codes fall out as a harmless no-operation.
    always_comb begin
        next_result  = byte_alu_pkg::BYTE_ZERO;
        next_to_file = 1'b0;
        next_to_acc  = 1'b0;
        upd_c        = 1'b0;
        upd_dc       = 1'b0;
        upd_z        = 1'b0;
        next_c       = 1'b0;
        next_dc      = 1'b0;
        case (instr_op)
            byte_alu_pkg::OP_ADD_IMMEDIATE_TO_ACC: begin
                next_result = sum9[7:0];
                next_to_acc = 1'b1;
                upd_c       = 1'b1;
                upd_dc      = 1'b1;
                upd_z       = 1'b1;
                next_c      = sum9[8];
                next_dc     = sum5[4];
            end
            byte_alu_pkg::OP_ADD_ACC_TO_FILE: begin
                next_result  = sum9[7:0];
                next_to_file = dest_is_file(instr_dest);
                next_to_acc  = !dest_is_file(instr_dest);
                upd_c        = 1'b1;
                upd_dc       = 1'b1;
                upd_z        = 1'b1;
                next_c       = sum9[8];
                next_dc      = sum5[4];
            end
            byte_alu_pkg::OP_AND_IMMEDIATE_WITH_ACC: begin
                next_result = acc & instr_immediate;
                next_to_acc = 1'b1;
                upd_z       = 1'b1;
            end
            byte_alu_pkg::OP_AND_ACC_WITH_FILE: begin
                next_result  = acc & file_rd_data;
                next_to_file = dest_is_file(instr_dest);
                next_to_acc  = !dest_is_file(instr_dest);
                upd_z        = 1'b1;
            end
            byte_alu_pkg::OP_FILE_BIT_CLEAR: begin
                next_result  = file_rd_data & ~bit_mask(instr_bit_idx);
                next_to_file = 1'b1;
            end
            byte_alu_pkg::OP_FILE_BIT_SET: begin
                next_result  = file_rd_data | bit_mask(instr_bit_idx);
                next_to_file = 1'b1;
            end
            byte_alu_pkg::OP_SUBTRACT_ACC_FROM_FILE: begin
                next_result  = diff9[7:0];
                next_to_file = dest_is_file(instr_dest);
                next_to_acc  = !dest_is_file(instr_dest);
                upd_c        = 1'b1;
                upd_dc       = 1'b1;
                upd_z        = 1'b1;
                next_c       = diff9[8];
                next_dc      = diff5[4];
            end
            byte_alu_pkg::OP_NIBBLE_EXCHANGE: begin
                next_result  = {file_rd_data[3:0], file_rd_data[7:4]};
                next_to_file = dest_is_file(instr_dest);
                next_to_acc  = !dest_is_file(instr_dest);
            end
            byte_alu_pkg::OP_XOR_IMMEDIATE_WITH_ACC: begin
                next_result = acc ^ instr_immediate;
                next_to_acc = 1'b1;
                upd_z       = 1'b1;
            end
            byte_alu_pkg::OP_XOR_ACC_WITH_FILE: begin
                next_result  = acc ^ file_rd_data;
                next_to_file = dest_is_file(instr_dest);
                next_to_acc  = !dest_is_file(instr_dest);
                upd_z        = 1'b1;
            end
            default: begin
                // No-operation and the bit test write nothing and keep the flags.
                next_result = byte_alu_pkg::BYTE_ZERO;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Accumulator
    // -----------------------------------------------------------------
    // Only an executing instruction that targets the accumulator loads it,
    // so an instruction caught in the skip slot leaves it untouched.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc <= byte_alu_pkg::ACC_RESET;
        end else if (exec && next_to_acc) begin
            acc <= next_result;
        end
    end

    // -----------------------------------------------------------------
    // File write-back
    // -----------------------------------------------------------------
    // Registered so the memory sees one clean write strobe a cycle after issue.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            file_wr_en   <= 1'b0;
            file_wr_addr <= '0;
            file_wr_data <= byte_alu_pkg::BYTE_ZERO;
        end else begin
            file_wr_en <= exec && next_to_file;
            if (exec && next_to_file) begin
                file_wr_addr <= instr_file_addr;
                file_wr_data <= next_result;
            end
        end
    end

    // -----------------------------------------------------------------
    // Status flags
    // -----------------------------------------------------------------
    // Each flag moves only for the operations that own it; the rest leave it alone.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            carry_flag      <= 1'b0;
            half_carry_flag <= 1'b0;
            zero_flag       <= 1'b0;
        end else if (exec) begin
            if (upd_c) begin
                carry_flag <= next_c;
            end
            if (upd_dc) begin
                half_carry_flag <= next_dc;
            end
            if (upd_z) begin
                zero_flag <= (next_result == byte_alu_pkg::BYTE_ZERO);
            end
        end
    end

endmodule

/* File: sim/file_memory_model.sv */
// Behavioural data memory file that answers the ALU read and write ports.
`timescale 1ns/1ps
module file_memory_model (
    // Clock
    input  wire logic       clk_sys,
    // Combinational read port
    input  wire logic [6:0] rd_addr,
    output logic [7:0]      rd_data,
    // Byte write port
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data
);
    logic [7:0] mem [128];

    // Preload varied bytes so operands differ from the first cycle.
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37 + 8'h5A);
        end
    end

    // A write lands at the edge that ends its strobe cycle, so a read in that cycle sees the old byte.
    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule

/* File: sim/byte_alu_props.sv */
// Concurrent checks on the ports of the byte ALU.
`timescale 1ns/1ps
module byte_alu_props #(
    parameter int ADDR_W = 7
) (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    // Instruction
    input wire logic                  instr_valid,
    input wire byte_alu_pkg::alu_op_t instr_op,
    input wire logic [7:0]            instr_immediate,
    input wire logic [ADDR_W-1:0]     instr_file_addr,
    input wire logic [2:0]            instr_bit_idx,
    input wire logic                  instr_dest,
    // File side
    input wire logic [7:0]            file_rd_data,
    input wire logic                  file_wr_en,
    input wire logic [ADDR_W-1:0]     file_wr_addr,
    input wire logic [7:0]            file_wr_data,
    // Accumulator, flags and skip slot
    input wire logic [7:0]            acc,
    input wire logic                  carry_flag,
    input wire logic                  half_carry_flag,
    input wire logic                  zero_flag,
    input wire logic                  skip_active
);
    // An instruction executes only when it is valid and outside the skip slot.
    logic ex;
    assign ex = instr_valid && !skip_active;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_add_imm_sum: assert property (
        ex && instr_op == byte_alu_pkg::OP_ADD_IMMEDIATE_TO_ACC
        |=> {carry_flag, acc} == $past({1'h0, acc} + {1'h0, instr_immediate}))
        else $error("add immediate sum or carry wrong");
    a_add_half_carry: assert property (
        ex && instr_op == byte_alu_pkg::OP_ADD_ACC_TO_FILE
        |=> half_carry_flag == $past(({1'h0, acc[3:0]} + {1'h0, file_rd_data[3:0]}) > 5'h0F))
        else $error("add half carry wrong");
    a_add_file_write: assert property (
        ex && instr_op == byte_alu_pkg::OP_ADD_ACC_TO_FILE && instr_dest
        |=> file_wr_en && file_wr_addr == $past(instr_file_addr) && file_wr_data == $past(8'(acc + file_rd_data)))
        else $error("add to file write wrong");
    a_swap_to_acc: assert property (
        ex && instr_op == byte_alu_pkg::OP_NIBBLE_EXCHANGE && !instr_dest
        |=> !file_wr_en && acc == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])}
            && $stable({carry_flag, half_carry_flag, zero_flag}))
        else $error("nibble exchange wrong");
    a_bit_clear_write: assert property (
        ex && instr_op == byte_alu_pkg::OP_FILE_BIT_CLEAR
        |=> file_wr_en && file_wr_data == $past(file_rd_data & ~(8'h01 << instr_bit_idx))
            && $stable({carry_flag, half_carry_flag, zero_flag}))
        else $error("bit clear wrong");
    a_skip_on_clear: assert property (
        ex && instr_op == byte_alu_pkg::OP_TEST_BIT_SKIP_IF_ZERO
        |=> skip_active == !$past(file_rd_data[instr_bit_idx]) && !file_wr_en && $stable(acc))
        else $error("skip decision wrong");
    a_skip_discards_next: assert property (
        instr_valid && skip_active |=> !file_wr_en && !skip_active && $stable({acc, zero_flag, carry_flag}))
        else $error("skipped instruction was not discarded");
    a_sub_no_borrow: assert property (
        ex && instr_op == byte_alu_pkg::OP_SUBTRACT_ACC_FROM_FILE
        |=> carry_flag == $past(file_rd_data >= acc) && half_carry_flag == $past(file_rd_data[3:0] >= acc[3:0]))
        else $error("subtract borrow flags wrong");
    a_xor_imm_zero: assert property (
        ex && instr_op == byte_alu_pkg::OP_XOR_IMMEDIATE_WITH_ACC
        |=> acc == $past(acc ^ instr_immediate) && zero_flag == (acc == 8'h00) && $stable(carry_flag))
        else $error("xor immediate wrong");
    a_and_file_zero: assert property (
        ex && instr_op == byte_alu_pkg::OP_AND_ACC_WITH_FILE && instr_dest
        |=> file_wr_data == $past(acc & file_rd_data) && zero_flag == (file_wr_data == 8'h00) && $stable(acc))
        else $error("and to file wrong");
endmodule

/* File: sim/byte_alu_tb_top.sv */
// Self-checking bench for the byte ALU against a data memory file model.
`timescale 1ns/1ps
module byte_alu_tb_top;
    logic                  clk_sys = 1'h0;
    logic                  sys_rst = 1'h1;
    logic                  instr_valid = 1'h0;
    byte_alu_pkg::alu_op_t instr_op = byte_alu_pkg::OP_NONE;
    logic [7:0]            instr_immediate = 8'h00;
    logic [6:0]            instr_file_addr = 7'h00;
    logic [2:0]            instr_bit_idx = 3'h0;
    logic                  instr_dest = 1'h0;
    logic [7:0]            file_rd_data, file_wr_data, acc;
    logic [6:0]            file_rd_addr, file_wr_addr;
    logic                  file_wr_en, carry_flag, half_carry_flag, zero_flag, skip_active, instr_accepted;
    // Expected state, kept by the bench alone.
    logic [7:0]            e_acc = 8'h00, e_wd = 8'h00;
    logic [6:0]            e_wa = 7'h00;
    logic                  e_c = 1'h0, e_h = 1'h0, e_z = 1'h0, e_skip = 1'h0, e_we = 1'h0;
    int                    fails = 0, num_checks = 0;
    logic [31:0]           seed = 32'h0001434E;

    // Free-running 20 MHz clock.
    always #25 clk_sys = ~clk_sys;

    byte_alu byte_alu_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_immediate(instr_immediate), .instr_file_addr(instr_file_addr), .instr_bit_idx(instr_bit_idx),
        .instr_dest(instr_dest), .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr), .file_wr_en(file_wr_en),
        .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .acc(acc), .carry_flag(carry_flag),
        .half_carry_flag(half_carry_flag), .zero_flag(zero_flag), .skip_active(skip_active),
        .instr_accepted(instr_accepted));
    file_memory_model file_memory_model_inst (.clk_sys(clk_sys), .rd_addr(file_rd_addr), .rd_data(file_rd_data),
        .wr_en(file_wr_en), .wr_addr(file_wr_addr), .wr_data(file_wr_data));

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("FAIL %0t %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    // Reference model; immediate forms are folded onto the file forms with the accumulator as target.
    function automatic void predict();
        logic [7:0] f, o, r;
        logic [8:0] s;
        logic       d, w;
        f = file_rd_data;
        o = (instr_op inside {4'h1, 4'h3, 4'hA}) ? instr_immediate : f;
        d = (instr_op inside {4'h1, 4'h3, 4'hA}) ? 1'h0 : instr_dest;
        w = 1'h1;
        r = 8'h00;
        e_we = 1'h0;
        if (sys_rst) begin
            {e_acc, e_c, e_h, e_z, e_skip, e_wa, e_wd} = '0;
        end else if (instr_valid && e_skip) begin
            e_skip = 1'h0;
        end else if (instr_valid) begin
            case (instr_op)
                byte_alu_pkg::OP_ADD_IMMEDIATE_TO_ACC, byte_alu_pkg::OP_ADD_ACC_TO_FILE: begin
                    s = e_acc + o;
                    r = s[7:0];
                    e_c = s[8];
                    e_h = (e_acc[3:0] + o[3:0]) > 5'h0F;
                end
                byte_alu_pkg::OP_AND_IMMEDIATE_WITH_ACC, byte_alu_pkg::OP_AND_ACC_WITH_FILE: r = e_acc & o;
                byte_alu_pkg::OP_XOR_IMMEDIATE_WITH_ACC, byte_alu_pkg::OP_XOR_ACC_WITH_FILE: r = e_acc ^ o;
                byte_alu_pkg::OP_SUBTRACT_ACC_FROM_FILE: begin
                    r = f - e_acc;
                    e_c = f >= e_acc;
                    e_h = f[3:0] >= e_acc[3:0];
                end
                byte_alu_pkg::OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
                byte_alu_pkg::OP_FILE_BIT_CLEAR: {d, r} = {1'h1, f & ~(8'h01 << instr_bit_idx)};
                byte_alu_pkg::OP_FILE_BIT_SET: {d, r} = {1'h1, f | (8'h01 << instr_bit_idx)};
                byte_alu_pkg::OP_TEST_BIT_SKIP_IF_ZERO: {w, e_skip} = {1'h0, !f[instr_bit_idx]};
                default: w = 1'h0;
            endcase
            if (instr_op inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hA, 4'hB}) begin
                e_z = (r == 8'h00);
            end
            if (w && d) begin
                {e_we, e_wa, e_wd} = {1'h1, instr_file_addr, r};
            end else if (w) begin
                e_acc = r;
            end
        end
    endfunction

    // One cycle: check what the last edge produced, drive the next instruction, then predict it.
    task automatic issue(input logic rst, input logic v, input logic [3:0] op, input logic [7:0] k,
                         input logic [6:0] a, input logic [2:0] b, input logic d);
        @(negedge clk_sys);
        check(acc, e_acc, "accumulator");
        check(carry_flag, e_c, "carry");
        check(half_carry_flag, e_h, "half carry");
        check(zero_flag, e_z, "zero");
        check(skip_active, e_skip, "skip");
        check(file_wr_en, e_we, "write strobe");
        if (e_we) begin
            check(file_wr_addr, e_wa, "write address");
            check(file_wr_data, e_wd, "write data");
        end
        sys_rst = rst;
        instr_valid = v;
        instr_op = byte_alu_pkg::alu_op_t'(op);
        instr_immediate = k;
        instr_file_addr = a;
        instr_bit_idx = b;
        instr_dest = d;
        #1;
        check(instr_accepted, v, "accepted");
        check(file_rd_addr, a, "read address");
        predict();
    endtask

    task automatic rnd_issue();
        logic [31:0] r;
        r = rnd();
        issue(1'h0, r[2:0] != 3'h0, 4'(r[7:4] % 4'hC), r[15:8], r[22:16], r[25:23], r[26]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Sequence: reset, corner cases, random traffic, mid-run reset
    // -----------------------------------------------------------------
    initial begin
        // Reset starts high at time zero, so four more cycles make five reset edges in all.
        repeat (4) issue(1'h1, 1'h0, 4'h0, 8'h00, 7'h00, 3'h0, 1'h0);
        // Codes: 1 add immediate, 5 clear, 6 set, 7 test; FF plus 01 wraps to zero with both carries.
        issue(1'h0, 1'h1, 4'h1, 8'hFF, 7'h00, 3'h0, 1'h0);
        issue(1'h0, 1'h1, 4'h1, 8'h01, 7'h00, 3'h0, 1'h0);
        // A cleared bit arms the skip; an idle cycle keeps it pending; the next add is discarded.
        issue(1'h0, 1'h1, 4'h5, 8'h00, 7'h05, 3'h3, 1'h0);
        issue(1'h0, 1'h0, 4'h0, 8'h00, 7'h00, 3'h0, 1'h0);
        issue(1'h0, 1'h1, 4'h7, 8'h00, 7'h05, 3'h3, 1'h0);
        issue(1'h0, 1'h0, 4'h0, 8'h00, 7'h00, 3'h0, 1'h0);
        issue(1'h0, 1'h1, 4'h1, 8'h33, 7'h00, 3'h0, 1'h0);
        issue(1'h0, 1'h1, 4'h6, 8'h00, 7'h05, 3'h3, 1'h0);
        issue(1'h0, 1'h0, 4'h0, 8'h00, 7'h00, 3'h0, 1'h0);
        issue(1'h0, 1'h1, 4'h7, 8'h00, 7'h05, 3'h3, 1'h0);
        issue(1'h0, 1'h1, 4'h1, 8'h33, 7'h00, 3'h0, 1'h0);
        repeat (600) rnd_issue();
        repeat (2) issue(1'h1, 1'h1, 4'h1, 8'h11, 7'h00, 3'h0, 1'h0);
        repeat (200) rnd_issue();
        issue(1'h0, 1'h0, 4'h0, 8'h00, 7'h00, 3'h0, 1'h0);
        summarize();
    end

    // The run needs about 820 cycles; this limit leaves ample margin.
    initial begin
        #200000;
        fails++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end
endmodule

bind byte_alu byte_alu_props #(.ADDR_W(ADDR_W)) byte_alu_props_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_immediate(instr_immediate),
    .instr_file_addr(instr_file_addr), .instr_bit_idx(instr_bit_idx), .instr_dest(instr_dest),
    .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .acc(acc), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .skip_active(skip_active));
